// ---- rtl/pte_pkg.sv ----
package pte_pkg;
    // build-time shape
    localparam int NPROBE = 4;
    localparam int PW     = 8;
    localparam int CW     = 16;
    localparam int NSTATE = 16;
    localparam int SW     = 4;
    localparam int NBR    = 3;
    localparam int BRW    = 17;
    localparam int PROG_W = 51;
    localparam int AW     = 8;
    localparam bit ADVANCED_BUILT = 1'b1;

    // register byte offsets and offset pages
    localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
    localparam logic [AW-1:0] OFS_PART    = 8'h04;
    localparam logic [AW-1:0] OFS_STATUS  = 8'h08;
    localparam logic [AW-1:0] OFS_TCOUNT  = 8'h0C;
    localparam logic [3:0]    PAGE_PCFG   = 4'h1;
    localparam logic [3:0]    PAGE_PBITS  = 4'h2;
    localparam logic [3:0]    PAGE_CNT    = 4'h3;
    localparam logic [AW-1:0] OFS_PROG_LO = 8'h40;
    localparam logic [AW-1:0] OFS_PROG_HI = 8'h44;
    localparam logic [AW-1:0] OFS_PROG_WR = 8'h48;

    // control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FUNC_LSB = 3;
    localparam int CTRL_EN_BIT   = 5;
    localparam int CTRL_RST_BIT  = 6;
    localparam int PART_SH_LSB   = 4;

    // probe config fields
    localparam int PCFG_W       = 19;
    localparam int PCFG_OP_LSB  = 0;
    localparam int PCFG_SGN_BIT = 3;
    localparam int PCFG_BIT_BIT = 4;
    localparam int PCFG_RDX_LSB = 5;
    localparam int PCFG_VAL_LSB = 8;
    localparam int PCFG_DC_LSB  = 16;
    localparam int PBITS_W      = 24;

    // branch word fields
    localparam int BR_COND_LSB = 0;
    localparam int BR_NEXT_LSB = 4;
    localparam int BR_TRIG_BIT = 8;
    localparam int BR_COP_LSB  = 9;
    localparam int BR_CIDX_LSB = 11;
    localparam int BR_FOP_LSB  = 13;
    localparam int BR_FIDX_LSB = 15;

    // branch condition selects
    localparam logic [3:0] COND_NEVER  = 4'h0;
    localparam logic [3:0] COND_ALWAYS = 4'h1;
    localparam logic [3:0] COND_GLOBAL = 4'h2;
    localparam logic [3:0] COND_PROBE  = 4'h3;
    localparam logic [3:0] COND_CNT    = 4'h7;
    localparam logic [3:0] COND_FLAG   = 4'hB;
    localparam logic [3:0] COND_NGLOB  = 4'hF;

    // reset values
    localparam logic [2:0]  RST_MODE = 3'h0;
    localparam logic [1:0]  RST_FUNC = 2'h0;
    localparam logic [CW-1:0] RST_LIM = 16'hFFFF;

    typedef enum logic [2:0] {
        PTE_MODE_CMP     = 3'b000,
        PTE_MODE_SEQ     = 3'b001,
        PTE_MODE_EXT     = 3'b010,
        PTE_MODE_CMP_EXT = 3'b011,
        PTE_MODE_SEQ_EXT = 3'b100
    } pte_mode_t;

    typedef enum logic [1:0] {
        PTE_AND  = 2'b00,
        PTE_OR   = 2'b01,
        PTE_NAND = 2'b10,
        PTE_NOR  = 2'b11
    } pte_func_t;

    typedef enum logic [2:0] {
        PTE_EQ = 3'b000,
        PTE_NE = 3'b001,
        PTE_LT = 3'b010,
        PTE_LE = 3'b011,
        PTE_GT = 3'b100,
        PTE_GE = 3'b101
    } pte_op_t;

    typedef enum logic [1:0] {
        PTE_RDX_BIN = 2'b00,
        PTE_RDX_HEX = 2'b01,
        PTE_RDX_OCT = 2'b10,
        PTE_RDX_DEC = 2'b11
    } pte_radix_t;

    typedef enum logic [2:0] {
        PTE_B0   = 3'b000,
        PTE_B1   = 3'b001,
        PTE_BX   = 3'b010,
        PTE_BR   = 3'b011,
        PTE_BF   = 3'b100,
        PTE_BB   = 3'b101,
        PTE_BN   = 3'b110
    } pte_bit_t;

    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_INC  = 2'h1;
    localparam logic [1:0] OP_SET  = 2'h1;
    localparam logic [1:0] OP_CLR  = 2'h2;
endpackage

// ---- rtl/pte_prog_if.sv ----
`timescale 1ns/100ps
interface pte_prog_if;
    import pte_pkg::*;
    logic              wr_en;
    logic [SW-1:0]     wr_addr;
    logic [PROG_W-1:0] wr_data;
    logic [SW-1:0]     rd_addr;
    logic [PROG_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ---- rtl/pte_prog_mem.sv ----
`timescale 1ns/100ps
module pte_prog_mem
    import pte_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    pte_prog_if.mem   prog
);
    typedef struct packed {
        logic [NSTATE-1:0][PROG_W-1:0] mem;
        logic [PROG_W-1:0]             q;
    } pte_mem_state_t;

    pte_mem_state_t st_reg;
    pte_mem_state_t st_next;

    // program words survive reset; only the read register clears
    always_comb begin
        st_next   = st_reg;
        st_next.q = st_reg.mem[prog.rd_addr];
        if (prog.wr_en) begin
            st_next.mem[prog.wr_addr] = prog.wr_data;
        end
        if (rst) begin
            st_next.q = '0;
        end
    end

    always_ff @(posedge clock) begin
        st_reg <= st_next;
    end

    assign prog.rd_data = st_reg.q;
endmodule

// ---- rtl/pte_trigger.sv ----
// Notes on behaviour
// R1: comparator result triggers only in comparator-alone or comparator-or-external mode.
// R2: probes not participating are don't care in the combination.
// R3: each comparator offers ==, !=, <, <=, >, >=.
// R4: compare value is tested against the live sampled probe value.
// R5: per-bit codes 0, 1, X, rising, falling, either edge.
// R6: no-transition code matches when bit equals its previous sample.
// R7: hex or octal don't-care digits mask their whole bit group.
// R8: relational compares may be unsigned or signed.
// R9: global function is AND, OR, NAND or NOR over participants.
// R10: AND all true; NOR all false.
// R11: OR any true; NAND any false.
// R12: shared probe ports allow only AND and NAND.
// R13: sequencer presence is a build-time choice.
// R14: sequencer has at most 16 states.
// R15: each state has one to three conditional branches.
// R16: up to four event counters.
// R17: up to four flags recording taken branches.
// R18: actions are goto, trigger, counter and flag operations.
// R19: sequencer triggers only if built and in a sequencer mode.
// R20: external-alone mode triggers on a rising external input.
// R21: or-external modes OR the external input with comparator or sequencer.
// R22: everything is evaluated on the sample clock edge.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module pte_trigger
    import pte_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [NPROBE-1:0][PW-1:0] probe_in,
    input  wire logic                      external_trigger_input,
    input  wire logic [AW-1:0]             reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [31:0]               reg_rdata,
    output logic                           trigger_out
);
    typedef struct packed {
        logic [2:0]                      mode;
        logic [1:0]                      func;
        logic                            en;
        logic [NPROBE-1:0]               part;
        logic [NPROBE-1:0]               shared;
        logic [NPROBE-1:0][PCFG_W-1:0]   pcfg;
        logic [NPROBE-1:0][PBITS_W-1:0]  pbits;
        logic [3:0][CW-1:0]              lim;
        logic [3:0][CW-1:0]              cnt;
        logic [3:0]                      flags;
        logic [SW-1:0]                   state;
        logic [31:0]                     prog_lo;
        logic [PROG_W-33:0]              prog_hi;
        logic [NPROBE-1:0][PW-1:0]       smp;
        logic [NPROBE-1:0][PW-1:0]       prev;
        logic [2:0]                      xs;
        logic                            xlvl;
        logic                            trig;
        logic [15:0]                     tcount;
        logic [31:0]                     rdata;
    } pte_state_t;

    pte_state_t st_reg;
    pte_state_t st_next;
    pte_prog_if prog ();

    pte_prog_mem u_mem (
        .clock (clock),
        .rst   (rst),
        .prog  (prog.mem)
    );

    // bits of one hex or octal digit that are don't care
    function automatic logic [PW-1:0] digit_mask(input logic [1:0] radix, input logic [2:0] dc);
        logic [PW-1:0] m;
        m = '0;
        if (radix == PTE_RDX_HEX) begin
            m = {{4{dc[1]}}, {4{dc[0]}}}; // R7
        end else if (radix == PTE_RDX_OCT) begin
            m = {{2{dc[2]}}, {3{dc[1]}}, {3{dc[0]}}}; // R7
        end
        return m;
    endfunction

    // one probe comparator
    function automatic logic probe_match(input logic [PCFG_W-1:0] cfg, input logic [PBITS_W-1:0] codes,
                                         input logic [PW-1:0] cur, input logic [PW-1:0] old);
        logic [PW-1:0] m;
        logic [PW-1:0] a;
        logic [PW-1:0] b;
        logic          lt;
        logic          eq;
        logic          hit;
        logic [2:0]    c;
        m   = ~digit_mask(cfg[PCFG_RDX_LSB +: 2], cfg[PCFG_DC_LSB +: 3]);
        a   = cur & m; // R4
        b   = cfg[PCFG_VAL_LSB +: PW] & m;
        eq  = (a == b);
        lt  = cfg[PCFG_SGN_BIT] ? ($signed(a) < $signed(b)) : (a < b); // R8
        hit = 1'b0;
        if (cfg[PCFG_BIT_BIT]) begin
            hit = 1'b1;
            for (int i = 0; i < PW; i++) begin
                c = codes[3*i +: 3];
                case (c) // R5
                    PTE_B0:  hit = hit & ~cur[i];
                    PTE_B1:  hit = hit & cur[i];
                    PTE_BR:  hit = hit & cur[i] & ~old[i];
                    PTE_BF:  hit = hit & ~cur[i] & old[i];
                    PTE_BB:  hit = hit & (cur[i] ^ old[i]);
                    PTE_BN:  hit = hit & (cur[i] ~^ old[i]); // R6
                    default: hit = hit;
                endcase
            end
            if (cfg[PCFG_OP_LSB +: 3] == PTE_NE) begin
                hit = ~hit;
            end
        end else begin
            case (cfg[PCFG_OP_LSB +: 3]) // R3
                PTE_EQ:  hit = eq;
                PTE_NE:  hit = ~eq;
                PTE_LT:  hit = lt;
                PTE_LE:  hit = lt | eq;
                PTE_GT:  hit = ~lt & ~eq;
                PTE_GE:  hit = ~lt;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    logic [NPROBE-1:0] cmp;
    logic [1:0]        func_eff;
    logic              fallback;
    logic              gcond;
    logic              seq_on;
    logic              seq_trig;
    logic              ext_rise;
    logic              cmp_trig;
    logic              trig_now;
    logic [BRW-1:0]    br;
    logic              br_hit;
    logic              taken;
    logic [3:0]        sel;
    logic [1:0]        ix;

    // comparators look at the registered sample, so prev is exactly one edge older
    always_comb begin
        for (int p = 0; p < NPROBE; p++) begin
            cmp[p] = probe_match(st_reg.pcfg[p], st_reg.pbits[p], st_reg.smp[p], st_reg.prev[p]); // R22
        end
    end

    // shared ports cannot OR or NOR; the request degrades to its AND form
    always_comb begin
        fallback = |(st_reg.part & st_reg.shared) & st_reg.func[0];
        func_eff = fallback ? {st_reg.func[1], 1'b0} : st_reg.func; // R12
        case (func_eff) // R9
            PTE_AND:  gcond = &(cmp | ~st_reg.part); // R10 R2
            PTE_OR:   gcond = |(cmp & st_reg.part); // R11 R2
            PTE_NAND: gcond = |(~cmp & st_reg.part); // R11
            PTE_NOR:  gcond = &(~cmp | ~st_reg.part); // R10
            default:  gcond = 1'b0;
        endcase
    end

    always_comb begin
        st_next  = st_reg;
        seq_on   = ADVANCED_BUILT && st_reg.en && // R13
                   (st_reg.mode == PTE_MODE_SEQ || st_reg.mode == PTE_MODE_SEQ_EXT); // R19
        seq_trig = 1'b0;
        taken    = 1'b0;
        br       = '0;
        br_hit   = 1'b0;
        sel      = '0;
        ix       = '0;

        // sample probes and external pin
        st_next.smp  = probe_in;
        st_next.prev = st_reg.smp;
        st_next.xs   = {st_reg.xs[1:0], external_trigger_input};
        if (st_reg.xs[1] == st_reg.xs[2]) begin
            st_next.xlvl = st_reg.xs[2];
        end
        ext_rise = (st_reg.xs[1] == st_reg.xs[2]) && st_reg.xs[2] && !st_reg.xlvl; // R20

        // sequencer: first true branch of the current state wins
        if (seq_on) begin
            for (int k = 0; k < NBR; k++) begin
                br  = prog.rd_data[k*BRW +: BRW];
                sel = br[BR_COND_LSB +: 4];
                ix  = sel[1:0] + 2'h1;
                if (sel == COND_NEVER) begin
                    br_hit = 1'b0;
                end else if (sel == COND_ALWAYS) begin
                    br_hit = 1'b1;
                end else if (sel == COND_GLOBAL) begin
                    br_hit = gcond;
                end else if (sel == COND_NGLOB) begin
                    br_hit = ~gcond;
                end else if (sel < COND_CNT) begin
                    br_hit = cmp[ix];
                end else if (sel < COND_FLAG) begin
                    br_hit = (st_reg.cnt[ix] == st_reg.lim[ix]); // R16
                end else begin
                    br_hit = st_reg.flags[ix]; // R17
                end
                if (br_hit && !taken) begin // R15
                    taken         = 1'b1;
                    st_next.state = br[BR_NEXT_LSB +: SW]; // R14 R18
                    seq_trig      = br[BR_TRIG_BIT]; // R18
                    if (br[BR_COP_LSB +: 2] == OP_INC) begin
                        st_next.cnt[br[BR_CIDX_LSB +: 2]] = st_reg.cnt[br[BR_CIDX_LSB +: 2]] + 16'h0001; // R16
                    end else if (br[BR_COP_LSB +: 2] == OP_CLR) begin
                        st_next.cnt[br[BR_CIDX_LSB +: 2]] = '0;
                    end
                    if (br[BR_FOP_LSB +: 2] == OP_SET) begin
                        st_next.flags[br[BR_FIDX_LSB +: 2]] = 1'b1; // R17
                    end else if (br[BR_FOP_LSB +: 2] == OP_CLR) begin
                        st_next.flags[br[BR_FIDX_LSB +: 2]] = 1'b0;
                    end
                end
            end
        end else begin
            st_next.state = '0;
            st_next.cnt   = '0;
            st_next.flags = '0;
        end

        cmp_trig = st_reg.en && gcond &&
                   (st_reg.mode == PTE_MODE_CMP || st_reg.mode == PTE_MODE_CMP_EXT); // R1
        trig_now = cmp_trig || seq_trig;
        if (st_reg.en && st_reg.mode == PTE_MODE_EXT) begin
            trig_now = ext_rise; // R20
        end else if (st_reg.en && (st_reg.mode == PTE_MODE_CMP_EXT || st_reg.mode == PTE_MODE_SEQ_EXT)) begin
            trig_now = trig_now || st_reg.xlvl; // R21
        end
        st_next.trig = trig_now; // R22
        if (trig_now) begin
            st_next.tcount = st_reg.tcount + 16'h0001;
        end

        // register writes
        if (reg_wr) begin
            if (reg_addr == OFS_CTRL) begin
                st_next.mode = reg_wdata[CTRL_MODE_LSB +: 3];
                st_next.func = reg_wdata[CTRL_FUNC_LSB +: 2];
                st_next.en   = reg_wdata[CTRL_EN_BIT];
                if (reg_wdata[CTRL_RST_BIT]) begin
                    st_next.state  = '0;
                    st_next.cnt    = '0;
                    st_next.flags  = '0;
                    st_next.tcount = '0;
                end
            end else if (reg_addr == OFS_PART) begin
                st_next.part   = reg_wdata[NPROBE-1:0];
                st_next.shared = reg_wdata[PART_SH_LSB +: NPROBE];
            end else if (reg_addr[7:4] == PAGE_PCFG) begin
                st_next.pcfg[reg_addr[3:2]] = reg_wdata[PCFG_W-1:0];
            end else if (reg_addr[7:4] == PAGE_PBITS) begin
                st_next.pbits[reg_addr[3:2]] = reg_wdata[PBITS_W-1:0];
            end else if (reg_addr[7:4] == PAGE_CNT) begin
                st_next.lim[reg_addr[3:2]] = reg_wdata[CW-1:0];
            end else if (reg_addr == OFS_PROG_LO) begin
                st_next.prog_lo = reg_wdata;
            end else if (reg_addr == OFS_PROG_HI) begin
                st_next.prog_hi = reg_wdata[PROG_W-33:0];
            end
        end

        // register reads, answered on the following cycle
        st_next.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == OFS_CTRL) begin
                st_next.rdata = {25'h0000000, 1'b0, st_reg.en, st_reg.func, st_reg.mode};
            end else if (reg_addr == OFS_PART) begin
                st_next.rdata = {24'h000000, st_reg.shared, st_reg.part};
            end else if (reg_addr == OFS_STATUS) begin
                st_next.rdata = {17'h00000, st_reg.trig, st_reg.xlvl, fallback,
                                 st_reg.state, st_reg.flags, cmp};
            end else if (reg_addr == OFS_TCOUNT) begin
                st_next.rdata = {16'h0000, st_reg.tcount};
            end else if (reg_addr[7:4] == PAGE_PCFG) begin
                st_next.rdata = {13'h0000, st_reg.pcfg[reg_addr[3:2]]};
            end else if (reg_addr[7:4] == PAGE_PBITS) begin
                st_next.rdata = {8'h00, st_reg.pbits[reg_addr[3:2]]};
            end else if (reg_addr[7:4] == PAGE_CNT) begin
                st_next.rdata = {st_reg.cnt[reg_addr[3:2]], st_reg.lim[reg_addr[3:2]]};
            end else if (reg_addr == OFS_PROG_LO) begin
                st_next.rdata = st_reg.prog_lo;
            end else if (reg_addr == OFS_PROG_HI) begin
                st_next.rdata = {13'h0000, st_reg.prog_hi};
            end
        end

        if (rst) begin
            st_next        = '0;
            st_next.mode   = RST_MODE;
            st_next.func   = RST_FUNC;
            st_next.lim    = {4{RST_LIM}};
        end
    end

    // memory read address follows the next state so its registered word lines up with state_reg
    assign prog.rd_addr = st_next.state;
    assign prog.wr_en   = reg_wr && (reg_addr == OFS_PROG_WR) && !rst;
    assign prog.wr_addr = reg_wdata[SW-1:0];
    assign prog.wr_data = {st_reg.prog_hi, st_reg.prog_lo};

    always_ff @(posedge clock) begin
        st_reg <= st_next;
    end

    assign reg_rdata   = st_reg.rdata;
    assign trigger_out = st_reg.trig;
endmodule

// ---- sim/pte_probe_src.sv ----
`timescale 1ns/100ps
module pte_probe_src
    import pte_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic [NPROBE-1:0][PW-1:0] want_probe,
    input  wire logic                      want_ext,
    output logic      [NPROBE-1:0][PW-1:0] probe_in,
    output logic                           external_trigger_input
);
    always_ff @(posedge clock) begin
        probe_in <= want_probe;
    end

    // async pin, kept off the edge
    always @(posedge clock) begin
        external_trigger_input <= #7 want_ext;
    end
endmodule

// ---- sim/pte_trigger_checker.sv ----
`timescale 1ns/100ps
module pte_trigger_checker
    import pte_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic [NPROBE-1:0][PW-1:0] probe_in,
    input  wire logic                      external_trigger_input,
    input  wire logic [AW-1:0]             reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [31:0]               reg_rdata,
    input  wire logic                      trigger_out
);
    logic [2:0] mode_reg;
    logic [1:0] func_reg;
    logic       en_reg;
    logic [3:0] part_reg;
    logic [7:0] cfg_age_reg;
    logic [7:0] ext_age_reg;
    logic       ext_old_reg;
    logic       settled;
    logic       or_mode;

    // config shadow; checks wait out writes
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_reg    <= 3'h0;
            func_reg    <= 2'h0;
            en_reg      <= 1'b0;
            part_reg    <= 4'h0;
            cfg_age_reg <= 8'h00;
            ext_age_reg <= 8'hFF;
            ext_old_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == OFS_CTRL) begin
                mode_reg <= reg_wdata[2:0];
                func_reg <= reg_wdata[4:3];
                en_reg   <= reg_wdata[5];
            end
            if (reg_wr && reg_addr == OFS_PART) begin
                part_reg <= reg_wdata[3:0];
            end
            cfg_age_reg <= reg_wr ? 8'h00 : cfg_age_reg + {7'h00, cfg_age_reg != 8'hFF};
            ext_old_reg <= external_trigger_input;
            ext_age_reg <= (external_trigger_input && !ext_old_reg) ? 8'h00 : ext_age_reg + {7'h00, ext_age_reg != 8'hFF};
        end
    end

    assign settled = en_reg && cfg_age_reg > 8'h04;
    assign or_mode = mode_reg == PTE_MODE_CMP_EXT || mode_reg == PTE_MODE_SEQ_EXT;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_ext_rise;
        !external_trigger_input ##1 external_trigger_input;
    endsequence

    sequence s_ext_held;
        external_trigger_input [*6];
    endsequence

    a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("stray read data");
    a_rd_unmapped: assert property ($past(reg_rd) && $past(reg_addr) == 8'hFC |-> reg_rdata == 32'h0)
        else $error("unmapped read data");
    a_reset_quiet: assert property ($past(rst) |-> !trigger_out && reg_rdata == 32'h0)
        else $error("busy after reset");
    a_off_quiet: assert property (!en_reg && cfg_age_reg > 8'h04 |-> !trigger_out)
        else $error("trigger while disabled");
    a_empty_func: assert property (settled && mode_reg == PTE_MODE_CMP && part_reg == 4'h0 |-> trigger_out == ~^func_reg)
        else $error("empty set level");
    a_ext_rise: assert property ((settled && mode_reg == PTE_MODE_EXT) ##0 s_ext_rise |-> ##[1:6] trigger_out)
        else $error("missed ext rise");
    a_ext_once: assert property (settled && mode_reg == PTE_MODE_EXT && trigger_out |=> !trigger_out)
        else $error("ext pulse too long");
    a_ext_cause: assert property (settled && mode_reg == PTE_MODE_EXT && trigger_out |-> ext_age_reg inside {[1:6]})
        else $error("ext trigger uncaused");
    a_or_ext: assert property (s_ext_held ##0 (or_mode && settled) |-> trigger_out)
        else $error("held ext ignored");
endmodule

bind pte_trigger pte_trigger_checker u_pte_trigger_checker (
    .clock                  (clock),
    .rst                    (rst),
    .probe_in               (probe_in),
    .external_trigger_input (external_trigger_input),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .trigger_out            (trigger_out)
);

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    import pte_pkg::*;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  part;
        logic [18:0] pcfg;
        logic [7:0]  p0;
        logic        ext;
        logic        hit;
    } pte_row_t;

    localparam pte_row_t ROWS [23] = '{
        '{8'h20, 8'h01, 19'h04000, 8'h40, 1'b0, 1'b1}, '{8'h20, 8'h01, 19'h04001, 8'h40, 1'b0, 1'b0},
        '{8'h20, 8'h01, 19'h04002, 8'h3F, 1'b0, 1'b1}, '{8'h20, 8'h01, 19'h04003, 8'h41, 1'b0, 1'b0},
        '{8'h20, 8'h01, 19'h04004, 8'h41, 1'b0, 1'b1}, '{8'h20, 8'h01, 19'h04005, 8'h3F, 1'b0, 1'b0},
        '{8'h20, 8'h01, 19'h0100A, 8'hF0, 1'b0, 1'b1}, '{8'h20, 8'h01, 19'h01002, 8'hF0, 1'b0, 1'b0},
        '{8'h20, 8'h01, 19'h25A20, 8'h3A, 1'b0, 1'b1}, '{8'h20, 8'h01, 19'h05A20, 8'h3A, 1'b0, 1'b0},
        '{8'h20, 8'h01, 19'h60740, 8'hFF, 1'b0, 1'b1}, '{8'h20, 8'h03, 19'h04000, 8'h40, 1'b0, 1'b0},
        '{8'h28, 8'h03, 19'h04000, 8'h40, 1'b0, 1'b1}, '{8'h30, 8'h03, 19'h04000, 8'h40, 1'b0, 1'b1},
        '{8'h38, 8'h03, 19'h04000, 8'h40, 1'b0, 1'b0}, '{8'h28, 8'h13, 19'h04000, 8'h40, 1'b0, 1'b0},
        '{8'h38, 8'h13, 19'h04000, 8'h40, 1'b0, 1'b1}, '{8'h20, 8'h00, 19'h04000, 8'h40, 1'b0, 1'b1},
        '{8'h28, 8'h00, 19'h04000, 8'h40, 1'b0, 1'b0}, '{8'h00, 8'h01, 19'h04000, 8'h40, 1'b0, 1'b0},
        '{8'h22, 8'h01, 19'h04000, 8'h40, 1'b0, 1'b0}, '{8'h23, 8'h01, 19'h04000, 8'h41, 1'b1, 1'b1},
        '{8'h23, 8'h01, 19'h04000, 8'h40, 1'b0, 1'b1}};
    localparam logic [7:0] CODE_HIT = 8'hC6;

    logic                      clock;
    logic                      rst;
    logic [NPROBE-1:0][PW-1:0] want_probe;
    logic                      want_ext;
    logic [NPROBE-1:0][PW-1:0] probe_in;
    logic                      external_trigger_input;
    logic [AW-1:0]             reg_addr;
    logic [31:0]               reg_wdata;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [31:0]               reg_rdata;
    logic                      trigger_out;
    logic [31:0]               rdat;
    int                        fails;
    int                        compares;

    pte_trigger u_pte_trigger (.clock(clock), .rst(rst), .probe_in(probe_in),
        .external_trigger_input(external_trigger_input), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_out(trigger_out));
    pte_probe_src u_pte_probe_src (.clock(clock), .want_probe(want_probe), .want_ext(want_ext),
        .probe_in(probe_in), .external_trigger_input(external_trigger_input));

    always #10 clock = ~clock;

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rdat = reg_rdata;
    endtask

    task automatic wait_trig();
        #1;
        repeat (8) begin
            if (trigger_out !== 1'b1) @(posedge clock) #1;
        end
        chk(trigger_out, 32'h1);
    endtask

    task automatic pulse_once();
        wait_trig();
        @(posedge clock);
        #1 chk(trigger_out, 32'h0);
    endtask

    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // run needs under 2000 cycles
    initial begin
        #100000;
        fails++;
        stop_test();
    end

    initial begin
        clock      = 1'b0;
        rst        = 1'b1;
        want_probe = '0;
        want_ext   = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        fails      = 0;
        compares   = 0;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        rd(OFS_CTRL);
        chk(rdat, 32'h0);
        rd(8'h30);
        chk(rdat, 32'h0000FFFF);
        rd(8'hFC);
        chk(rdat, 32'h0);
        wr(OFS_CTRL, 32'h6B);
        wr(8'hFC, 32'hFF);
        rd(OFS_CTRL);
        chk(rdat, 32'h2B);
        foreach (ROWS[i]) begin
            wr(8'h10, {13'h0, ROWS[i].pcfg});
            wr(OFS_PART, {24'h0, ROWS[i].part});
            wr(OFS_CTRL, {24'h0, ROWS[i].ctrl});
            want_probe <= {24'hA55A11, ROWS[i].p0};
            want_ext   <= ROWS[i].ext;
            repeat (10) @(posedge clock);
            #1 chk(trigger_out, {31'h0, ROWS[i].hit});
        end
        wr(8'h10, 32'h10);
        want_probe <= {24'hA55A11, 8'h01};
        for (int c = 0; c < 8; c++) begin
            wr(8'h20, 32'h492490 | c);
            repeat (6) @(posedge clock);
            #1 chk(trigger_out, {31'h0, CODE_HIT[c]});
        end
        wr(8'h20, 32'h492493);
        want_probe <= {24'hA55A11, 8'h00};
        repeat (4) @(posedge clock);
        want_probe <= {24'hA55A11, 8'h01};
        pulse_once();
        wr(OFS_CTRL, 32'h22);
        repeat (10) @(posedge clock);
        want_ext <= 1'b1;
        pulse_once();
        // memory survives reset: write every used state
        wr(OFS_PROG_LO, 32'h51);
        wr(OFS_PROG_HI, 32'h0);
        wr(OFS_PROG_WR, 32'h0);
        wr(OFS_PROG_LO, 32'h351);
        wr(OFS_PROG_WR, 32'h5);
        wr(OFS_CTRL, 32'h61);
        wait_trig();
        rd(OFS_STATUS);
        chk({28'h0, rdat[11:8]}, 32'h5);
        wr(OFS_CTRL, 32'h20);
        repeat (6) @(posedge clock);
        #1 chk(trigger_out, 32'h0);
        stop_test();
    end
endmodule
